// *** core/block_pager.sv ***
/*
 * Backplane block pager. Builds the 250-word input image word by word
 * and takes the 248-word output image word by word, keeping parameter and read data in
 * a 5000-word database. Assumes the backplane side streams the images
 * one word per cycle with a first-word strobe only, and that
 * the host always finishes an image it has started.
 */
`timescale 1ns/100ps

module block_pager
  import page_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Output image from host, one word per cycle
  input  wire logic        out_valid,
  input  wire logic        out_first,
  input  wire logic [15:0] out_word,
  // Input image toward host, one word per cycle
  input  wire logic        in_req,
  output logic             in_valid,
  output logic             in_last,
  output logic [15:0]      in_word,
  // Break requests from network and debug port
  input  wire logic        cmd_req,
  // Local database port for the serial side
  input  wire logic [12:0] db_addr,
  output logic [15:0]      db_rdata,
  // Status
  output logic             run_enable,
  output logic [15:0]      block_errors
);

  // ***********************************************************************
  // Storage
  // ***********************************************************************
  logic [15:0] db_mem [0:DB_WORDS-1];              // see [RL3]
  logic [15:0] cfg_err_r [0:1];

  boot_type    boot_r;
  logic [12:0] cnt_r;
  logic [3:0]  rd_blk_r;
  logic [1:0]  wr_blk_r;
  logic [1:0]  wr_ask_r;
  logic [7:0]  in_pos_r;
  logic [7:0]  out_pos_r;
  logic [15:0] out_id_r;
  logic        cfg_ok_r;
  logic [15:0] scan_r, rd_cnt_r, wr_cnt_r, parse_cnt_r;

  // ***********************************************************************
  // Decoding of incoming write blocks
  // ***********************************************************************
  wire [15:0] cur_id     = out_first ? out_word : out_id_r;
  wire        id_cfg     = cur_id == CFG_CODE;
  wire        id_param   = cur_id == 16'h0001 || cur_id == 16'h0002;
  wire        in_cfg_now = boot_r == ST_CFG_WAIT;
  // Payload position is only meaningful after word 0 has passed
  wire        wr_data    = out_valid && !out_first && id_param && !in_cfg_now
                           && out_pos_r <= WR_DATA_LAST;  // see [RL18]
  wire [12:0] wr_addr    = WR_DB_BASE
                           + 13'((cur_id[1:0] - 2'h1) * WR_DATA_WORDS)
                           + 13'(out_pos_r - 8'h01);   // see [RL17]
  wire        cfg_word   = out_valid && !out_first && id_cfg && in_cfg_now;
  wire        last_out   = out_valid && out_pos_r == 8'(OUT_WORDS - 1);
  // Zero setting in a port's first word is taken as a fault
  wire        cfg_bad    = cfg_word && out_word == 16'h0000
                           && (out_pos_r == 8'(PORT1_FIRST)
                               || out_pos_r == 8'(PORT2_LAST));
  wire        cfg_port   = out_pos_r >= 8'(PORT2_LAST);

  // ***********************************************************************
  // Building the input image
  // ***********************************************************************
  wire        status_blk = rd_blk_r == 4'h0;
  wire [12:0] rd_addr    = 13'((rd_blk_r - 4'h1) * RD_DATA_WORDS)
                           + 13'(in_pos_r - RD_DATA_FIRST);
  wire [15:0] cfg_image  =
      in_pos_r == 8'h01 ? CFG_CODE :
      in_pos_r == 8'h02 ? cfg_err_r[0] :
      in_pos_r == 8'h03 ? cfg_err_r[1] :
      in_pos_r == RD_ID_LAST ? CFG_TAIL : 16'h0000;   // see [RL8]
  wire [15:0] st_image   =
      in_pos_r == ST_SCAN      ? scan_r :
      in_pos_r == ST_RD_CNT    ? rd_cnt_r :
      in_pos_r == ST_WR_CNT    ? wr_cnt_r :
      in_pos_r == ST_PARSE_CNT ? parse_cnt_r :
      in_pos_r == ST_ERR_CNT   ? block_errors : 16'h0000;   // see [RL19]
  wire [15:0] rd_image   =
      (in_pos_r == 8'h00 || in_pos_r == RD_ID_LAST) ? {12'h000, rd_blk_r} :
      in_pos_r == 8'h01 ? {14'h0000, wr_blk_r} :
      (in_pos_r >= RD_DATA_FIRST && in_pos_r <= RD_DATA_LAST)
        ? db_mem[rd_addr] : 16'h0000;                  // see [RL12]
  wire [15:0] img_word   = in_cfg_now ? cfg_image :
                           status_blk ? st_image : rd_image;
  wire        img_ok     = in_cfg_now || boot_r == ST_RUN;
  wire        img_step   = in_req && img_ok;
  wire        img_end    = img_step && in_pos_r == 8'(IN_WORDS - 1);
  // Only a block other than the one last asked for breaks the cycle;
  // before the first request any parameter block is taken in order
  wire        wr_odd     = out_valid && out_first && id_param && !in_cfg_now
                           && wr_ask_r != 2'h0 && out_word[1:0] != wr_ask_r;
  wire        cyc_brk    = wr_odd || (cmd_req && img_end);    // see [RL15]

  // ***********************************************************************
  // Start-up sequence
  // ***********************************************************************
  wire        cnt_done   = cnt_r == 13'(HW_INIT_CYC - 1);
  wire        clr_done   = cnt_r == 13'(DB_WORDS - 1);
  // Initialise in order, clear RAM, wait for a clean config, then run
  always_ff @(posedge core_clk) begin                 // see [RL4]
    if (!resetn) begin
      boot_r <= ST_HW_INIT;
      cnt_r  <= 13'h0000;
    end else begin
      case (boot_r)
        ST_HW_INIT: begin
          cnt_r <= cnt_done ? 13'h0000 : cnt_r + 13'h0001;
          if (cnt_done) boot_r <= ST_BP_INIT;
        end
        ST_BP_INIT:   boot_r <= ST_RAM_CLR;
        ST_RAM_CLR: begin
          cnt_r <= clr_done ? 13'h0000 : cnt_r + 13'h0001;
          if (clr_done) boot_r <= ST_PORT_INIT;
        end
        ST_PORT_INIT: boot_r <= ST_CFG_WAIT;          // see [RL6]
        ST_CFG_WAIT:
          if (last_out && cfg_ok_r && !cfg_bad) begin // see [RL9]
            boot_r <= ST_REG_INIT;
          end
        ST_REG_INIT:  boot_r <= ST_RUN;
        ST_RUN:       boot_r <= ST_RUN;
        default:      boot_r <= ST_HW_INIT;
      endcase
    end
  end

  // ***********************************************************************
  // Database writes: clear at start-up, then host parameter data
  // ***********************************************************************
  always_ff @(posedge core_clk) begin
    if (boot_r == ST_RAM_CLR) begin
      db_mem[cnt_r] <= 16'h0000;
    end else if (wr_data) begin
      db_mem[wr_addr] <= out_word;
    end
  end

  // ***********************************************************************
  // Output image tracking and configuration checking
  // ***********************************************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      out_pos_r    <= 8'h00;
      out_id_r     <= 16'h0000;
      cfg_ok_r     <= 1'b0;
      cfg_err_r[0] <= 16'h0000;
      cfg_err_r[1] <= 16'h0000;
      block_errors <= 16'h0000;
      wr_cnt_r     <= 16'h0000;
      parse_cnt_r  <= 16'h0000;
    end else if (out_valid) begin
      out_pos_r <= last_out ? 8'h00 : out_pos_r + 8'h01;  // see [RL2]
      if (out_first) begin
        out_id_r <= out_word;
        wr_cnt_r <= wr_cnt_r + 16'h0001;
        cfg_ok_r <= id_cfg && in_cfg_now;             // see [RL7]
        if (id_cfg && in_cfg_now) begin
          cfg_err_r[0] <= 16'h0000;
          cfg_err_r[1] <= 16'h0000;
        end
        // Unknown number: data dropped, error counted
        if (!id_cfg && !id_param) begin               // see [RL20]
          block_errors <= block_errors + 16'h0001;
        end
      end
      if (cfg_bad) begin                              // see [RL9]
        cfg_ok_r <= 1'b0;
        cfg_err_r[cfg_port] <= cfg_err_r[cfg_port] | 16'h0001;
      end
      if (last_out && ((id_param && !in_cfg_now) || cfg_ok_r)) begin
        parse_cnt_r <= parse_cnt_r + 16'h0001;
      end
    end
  end

  // ***********************************************************************
  // Input image sequencing and block numbering
  // ***********************************************************************
  // Read numbers 1..10 then status 0; write numbers 1,2 step on their own
  always_ff @(posedge core_clk) begin                 // see [RL14]
    if (!resetn) begin
      in_pos_r <= 8'h00;
      rd_blk_r <= 4'h1;
      wr_blk_r <= 2'h1;
      wr_ask_r <= 2'h0;
      in_valid <= 1'b0;
      in_last  <= 1'b0;
      in_word  <= 16'h0000;
      scan_r   <= 16'h0000;
      rd_cnt_r <= 16'h0000;
    end else begin
      in_valid <= img_step;
      in_last  <= img_end;                            // see [RL1]
      in_word  <= img_word;
      if (img_step) begin
        in_pos_r <= img_end ? 8'h00 : in_pos_r + 8'h01;
      end
      if (img_end && !in_cfg_now) begin
        rd_cnt_r <= rd_cnt_r + 16'h0001;
        rd_blk_r <= rd_blk_r == RD_BLOCKS ? 4'h0 :
                    rd_blk_r + 4'h1;                  // see [RL11]
        if (status_blk) begin
          scan_r <= scan_r + 16'h0001;
        end else begin
          wr_ask_r <= wr_blk_r;
          wr_blk_r <= wr_blk_r == WR_BLOCKS ? 2'h1 : wr_blk_r + 2'h1;
        end
      end
      // Out-of-sequence host block or command restarts from read block 1
      if (cyc_brk) begin
        rd_blk_r <= 4'h1;                             // see [RL15]
      end
    end
  end

  // ***********************************************************************
  // Status outputs and serial-side database read
  // ***********************************************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      run_enable <= 1'b0;
      db_rdata   <= 16'h0000;
    end else begin
      run_enable <= boot_r == ST_RUN;                 // see [RL5]
      db_rdata   <= db_mem[db_addr];                  // see [RL10]
    end
  end

  // ***********************************************************************
  // Checks on what the block drives
  // ***********************************************************************
  // Last numbered read image closing with no break in the same cycle
  sequence s_last_rd_end;
    img_end && !in_cfg_now && rd_blk_r == RD_BLOCKS && !cyc_brk;
  endsequence

  a_cfg_gate: assert property (                       // see [RL5]
    @(posedge core_clk) disable iff (!resetn)
    boot_r == ST_CFG_WAIT |=> !run_enable)
    else $error("ran before configuration");
  a_img_len: assert property (                        // see [RL1]
    @(posedge core_clk) disable iff (!resetn)
    in_last |-> $past(in_pos_r) == RD_ID_LAST)
    else $error("input image length wrong");
  a_blk_range: assert property (                      // see [RL11]
    @(posedge core_clk) disable iff (!resetn)
    rd_blk_r <= RD_BLOCKS && wr_blk_r >= 2'h1)
    else $error("block number out of range");
  a_early_refuse: assert property (                   // see [RL4]
    @(posedge core_clk) disable iff (!resetn)
    in_req && !img_ok |=> !in_valid)
    else $error("word given before start-up done");
  a_status_next: assert property (                    // see [RL19]
    @(posedge core_clk) disable iff (!resetn)
    s_last_rd_end |=> status_blk)
    else $error("status block did not follow");
  a_err_count: assert property (                      // see [RL20]
    @(posedge core_clk) disable iff (!resetn)
    out_valid && out_first && !id_cfg && !id_param
      |=> block_errors == $past(block_errors) + 16'h0001)
    else $error("unknown block not counted");

endmodule

// *** core/page_pkg.sv ***
/*
 * Constants for the backplane block pager: image sizes, block word
 * offsets, block numbers, database span and start-up timing.
 * Assumes a single 20 MHz core clock shared by every user of the package.
 */
// Operation
// [RL1] Input image toward host is 250 sixteen-bit words per transfer.
// [RL2] Output image from host is 248 words per transfer.
// [RL3] Internal word database spans addresses 0 through 4999.
// [RL4] Start-up: hardware, backplane, RAM clear, ports, config, registers, run.
// [RL5] No network traffic until general configuration block has arrived.
// [RL6] On restart, request configuration by placing needed block number in read block.
// [RL7] Host config block: word 0 code 9000, port settings, rest spare.
// [RL8] Config request block: word 1 is 9000, words 2-3 errors, 249 is -2.
// [RL9] Config faults set error bits; operation waits for corrected config.
// [RL10] Normal operation pages database registers 0 to 4499 plus status; code pages only 0 to 1999 out and 2000 to 2429 in.
// [RL11] Ten read block numbers outward, two write block numbers inward.
// [RL12] Read block: number in words 0 and 249, write request, 200 data words.
// [RL13] Host stores read block data at a place chosen by its number.
// [RL14] Read and write block numbers step cyclically and independently.
// [RL15] Out-of-sequence write block or command/debug request breaks the cycle.
// [RL16] Host write block: number 1 or 2, 215 data words, spare rest.
// [RL17] Write block number selects where its data lands in the database.
// [RL18] Ten response blocks out; up to 247 words and two blocks in.
// [RL19] After last read block, send status block numbered 0 with counters.
// [RL20] Unknown write block numbers are ignored and counted as block errors.
package page_pkg;

  // ***********************************************************************
  // Image and database sizes
  // ***********************************************************************
  localparam int          IN_WORDS      = 250;
  localparam int          OUT_WORDS     = 248;
  localparam int          DB_WORDS      = 5000;
  localparam int          DB_AW         = 13;
  localparam int          IMG_AW        = 8;

  // ***********************************************************************
  // Block layout
  // ***********************************************************************
  localparam logic [15:0] CFG_CODE      = 16'h2328; // 9000
  localparam logic [15:0] CFG_TAIL      = 16'hFFFE; // -2
  localparam logic [7:0]  RD_ID_LAST    = 8'hF9;    // word 249
  localparam logic [7:0]  RD_DATA_FIRST = 8'h02;
  localparam logic [7:0]  RD_DATA_LAST  = 8'hC9;    // word 201
  localparam logic [7:0]  WR_DATA_LAST  = 8'hD7;    // word 215
  localparam int          RD_DATA_WORDS = 200;
  localparam int          WR_DATA_WORDS = 215;
  localparam logic [3:0]  RD_BLOCKS     = 4'hA;
  localparam logic [1:0]  WR_BLOCKS     = 2'h2;
  localparam logic [12:0] WR_DB_BASE    = 13'h07D0; // parameters from 2000
  localparam logic [4:0]  PORT1_FIRST   = 5'h01;
  localparam logic [4:0]  PORT2_LAST    = 5'h11;    // word 17 starts port 2
  localparam logic [4:0]  PORT_SPAN_END = 5'h1F;    // words up to 31 seen
  localparam logic [5:0]  PORT2_END     = 6'h21;    // word 33

  // Status block words
  localparam logic [7:0]  ST_SCAN       = 8'h02;
  localparam logic [7:0]  ST_RD_CNT     = 8'h19;
  localparam logic [7:0]  ST_WR_CNT     = 8'h1A;
  localparam logic [7:0]  ST_PARSE_CNT  = 8'h1B;
  localparam logic [7:0]  ST_ERR_CNT    = 8'h1E;

  // ***********************************************************************
  // Start-up timing
  // ***********************************************************************
  localparam int          CLK_MHZ       = 20;
  localparam int          HW_INIT_US    = 10;
  localparam int          HW_INIT_CYC   = HW_INIT_US * CLK_MHZ;

  typedef enum {
    ST_HW_INIT, ST_BP_INIT, ST_RAM_CLR, ST_PORT_INIT, ST_CFG_WAIT,
    ST_REG_INIT, ST_RUN
  } boot_type;

endpackage

// *** sim/block_pager_tb_top.sv ***
/*
 * Self-checking bench for the block pager: boot, configuration
 * handshake, write paging, read cycle and cycle breaks. Assumes the
 * host model drives the output image and requests the input image.
 */
`timescale 1ns/100ps

module block_pager_tb_top;
  import page_pkg::*;
  logic        core_clk;
  logic        resetn;
  logic        cmd_req;
  logic [12:0] db_addr;
  wire         out_valid, out_first, in_req, in_valid, in_last, run_enable;
  wire  [15:0] out_word, in_word, db_rdata, block_errors;
  int          bad_count;
  int          num_checks;
  int          errs;
  int          n;
  logic [15:0] db_exp [int];

  block_pager dut_u (.core_clk(core_clk), .resetn(resetn),
    .out_valid(out_valid), .out_first(out_first), .out_word(out_word),
    .in_req(in_req), .in_valid(in_valid), .in_last(in_last),
    .in_word(in_word), .cmd_req(cmd_req), .db_addr(db_addr),
    .db_rdata(db_rdata), .run_enable(run_enable),
    .block_errors(block_errors));

  host_model host_u (.core_clk(core_clk), .out_valid(out_valid),
    .out_first(out_first), .out_word(out_word), .in_req(in_req),
    .in_valid(in_valid), .in_last(in_last), .in_word(in_word));

  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ********************************************************************
  // Compare and stimulus tasks
  // ********************************************************************
  task chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task chk_img(input int k, input logic [15:0] exp);
    chk(host_u.rimg[k], exp, $sformatf("image word %0d", k));
  endtask

  // Random nonzero payload; model records where data must land
  task send_blk(input logic [15:0] id, input bit zero1);
    int i;
    logic [15:0] v;
    host_u.wimg[0] = id;
    for (i = 1; i < 248; i++) begin
      v = 16'($urandom);
      host_u.wimg[i] = (i > 215) ? 16'h0000 : (v | 16'h0001);
    end
    if (zero1) host_u.wimg[1] = 16'h0000;
    if (id == 1 || id == 2)
      for (i = 1; i <= 215; i++)
        db_exp[2000 + (id - 1) * 215 + i - 1] = host_u.wimg[i];
    host_u.send_img();
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected 13k cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    resetn = 1'b0;
    cmd_req = 1'b0;
    db_addr = 13'h0000;
    bad_count = 0;
    num_checks = 0;
    errs = 0;
    void'($urandom(40));
    repeat (16) @(posedge core_clk);
    #1 resetn = 1'b1;
    host_u.get_img();
    chk(host_u.rcnt[15:0], 16'h0000, "early words");
    chk({15'h0000, run_enable}, 16'h0000, "early run");
    $display("test boot done");
    repeat (5300) @(posedge core_clk);
    host_u.get_img();
    chk(host_u.rcnt[15:0], 16'h00FA, "image length");
    chk({15'h0000, host_u.last_ok}, 16'h0001, "last mark");
    chk_img(1, CFG_CODE);
    chk_img(2, 16'h0000);
    chk_img(249, CFG_TAIL);
    send_blk(CFG_CODE, 1'b1);
    host_u.get_img();
    chk_img(2, 16'h0001);
    chk({15'h0000, run_enable}, 16'h0000, "run on bad cfg");
    send_blk(CFG_CODE, 1'b0);
    for (n = 0; n < 100 && run_enable !== 1'b1; n++) @(posedge core_clk);
    chk({15'h0000, run_enable}, 16'h0001, "run after cfg");
    $display("test config done");
    send_blk(16'h0001, 1'b0);
    send_blk(16'h0002, 1'b0);
    send_blk(16'h0005, 1'b0);
    errs++;
    chk(block_errors, errs[15:0], "block errors");
    foreach (db_exp[a]) begin
      @(posedge core_clk);
      #1 db_addr = a[12:0];
      repeat (2) @(posedge core_clk);
      chk(db_rdata, db_exp[a], "db word");
    end
    $display("test write done");
    for (n = 1; n <= 10; n++) begin
      host_u.get_img();
      chk_img(0, n[15:0]);
      chk_img(249, n[15:0]);
      chk_img(1, (n % 2) ? 16'h0001 : 16'h0002);
      chk_img(201, 16'h0000);
    end
    host_u.get_img();
    chk_img(1, 16'h0000);
    chk_img(30, errs[15:0]);
    // Ten read images, five write images, three of them parsed
    chk_img(25, 16'h000A);
    chk_img(26, 16'h0005);
    chk_img(27, 16'h0003);
    $display("test read cycle done");
    host_u.get_img();
    cmd_req = 1'b1;
    host_u.get_img();
    cmd_req = 1'b0;
    host_u.get_img();
    chk_img(0, 16'h0001);
    send_blk(16'h0002, 1'b0);
    host_u.get_img();
    chk_img(0, 16'h0001);
    // Answering the block just asked for keeps the cycle going
    send_blk(16'h0002, 1'b0);
    host_u.get_img();
    chk_img(0, 16'h0002);
    $display("test break done");
    print_verdict();
  end
endmodule

// *** sim/host_model.sv ***
/*
 * Host side model: streams 248-word output images and collects
 * 250-word input images. Assumes one shared core clock.
 */
`timescale 1ns/100ps

module host_model (
  // Clock
  input  wire logic        core_clk,
  // Output image toward the pager
  output logic             out_valid,
  output logic             out_first,
  output logic [15:0]      out_word,
  // Input image from the pager
  output logic             in_req,
  input  wire logic        in_valid,
  input  wire logic        in_last,
  input  wire logic [15:0] in_word
);
  logic [15:0] wimg [248];
  logic [15:0] rimg [250];
  int          rcnt;
  logic        last_ok;

  // Idle lines at time zero
  initial begin
    out_valid = 1'b0;
    out_first = 1'b0;
    out_word  = 16'h0000;
    in_req    = 1'b0;
  end

  // Whole 248-word image, one word a cycle
  task send_img;
    int i;
    @(posedge core_clk);
    for (i = 0; i < 248; i++) begin
      #1 out_valid = 1'b1;
      out_first = (i == 0);
      out_word  = wimg[i];
      @(posedge core_clk);
    end
    #1 out_valid = 1'b0;
    out_first = 1'b0;
    out_word  = ~out_word; // Released line must not keep last word
  endtask

  // 250 requests; words kept in order for the host table
  task get_img;
    int k;
    int c;
    k = 0;
    last_ok = 1'b0;
    @(posedge core_clk);
    #1 in_req = 1'b1;
    // Words looked at just after the edge that launches them
    for (c = 0; c < 262 && k < 250; c++) begin
      @(posedge core_clk);
      #1;
      if (c == 249) in_req = 1'b0;
      if (in_valid === 1'b1) begin
        if (k == 249) last_ok = (in_last === 1'b1);
        rimg[k] = in_word;
        k++;
      end
    end
    rcnt = k;
  endtask
endmodule
